// *** logic/rlm_pkg.sv ***
/*
 * constants shared by the loss-of-signal monitor: thresholds, window
 * sizes, register map, field positions and reset values.
 * assumes one 50 MHz clock and a 4-bit AXI4-Lite byte address.
 */
package rlm_pkg;
    // ********************************************************
    // loss declaration and clearing thresholds, in bits
    // ********************************************************
    localparam int ZCNT_W           = 13;
    localparam int WCNT_W           = 8;
    localparam logic [ZCNT_W-1:0] E1_LOSS_ZEROS   = 13'h0020;
    localparam logic [ZCNT_W-1:0] EXT_LOSS_ZEROS  = 13'h1000;
    localparam logic [ZCNT_W-1:0] T1_LOSS_ZEROS   = 13'h00AF;
    localparam logic [WCNT_W-1:0] E1_WIN_BITS     = 8'h20;
    localparam logic [WCNT_W-1:0] E1_WIN_ONES     = 8'h04;
    localparam logic [WCNT_W-1:0] E1_MAX_ZERO_RUN = 8'h10;
    localparam logic [WCNT_W-1:0] T1_WIN_BITS     = 8'h80;
    localparam logic [WCNT_W-1:0] T1_WIN_ONES     = 8'h10;
    localparam logic [WCNT_W-1:0] T1_MAX_ZERO_RUN = 8'h64;
    localparam int JA_DELAY_BITS    = 16;

    // ********************************************************
    // register map
    // ********************************************************
    localparam int ADDR_W           = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFFS  = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_OFFS  = 4'h4;
    localparam logic [ADDR_W-1:0] ALARM_OFFS = 4'h8;
    localparam logic [ADDR_W-1:0] ENA_OFFS   = 4'hC;
    localparam int CTRL_T1_BIT      = 0;
    localparam int CTRL_EXT_BIT     = 1;
    localparam int CTRL_RECEIVER_POWER_ON_BIT    = 2;
    localparam int CTRL_DEC_BIT     = 3;
    localparam int CTRL_JA_BIT      = 4;
    localparam int CTRL_W           = 5;
    localparam int STAT_LOSS_BIT    = 0;
    localparam int STAT_RXEN_BIT    = 1;
    localparam int STAT_HW_BIT      = 2;
    localparam int ALARM_LOSS_BIT   = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/rlm_bit_if.sv ***
/*
 * carries the sampled bit stream and mode bits from the top to the
 * loss detector, and the loss state back.
 * assumes both ends run on aclk.
 */
interface rlm_bit_if;
    logic bit_strobe;
    logic bit_one;
    logic low_level;
    logic t1_mode;
    logic ext_loss;
    logic loss;
    logic loss_event;

    modport src
    (
        output bit_strobe, bit_one, low_level, t1_mode, ext_loss,
        input  loss, loss_event
    );
    modport mon
    (
        input  bit_strobe, bit_one, low_level, t1_mode, ext_loss,
        output loss, loss_event
    );
endinterface

// *** logic/rlm_los_detect.sv ***
/*
 * zero-run loss declaration and ones-density loss clearing.
 * assumes low_level is already synchronised and bit_strobe is one
 * cycle wide per received bit.
 */
module rlm_los_detect
(
    input  wire logic aclk,
    input  wire logic aresetn,
    rlm_bit_if.mon    bits
);
    typedef enum logic {RLM_SIGNAL, RLM_LOSS} rlm_state_type;

    function automatic logic [rlm_pkg::ZCNT_W-1:0] zero_limit
    (
        input logic t1,
        input logic ext
    );
        if (t1)
            return rlm_pkg::T1_LOSS_ZEROS;
        else if (ext)
            return rlm_pkg::EXT_LOSS_ZEROS;
        else
            return rlm_pkg::E1_LOSS_ZEROS;
    endfunction

    rlm_state_type               state_reg;
    logic [rlm_pkg::ZCNT_W-1:0]  zrun_reg;
    logic [rlm_pkg::WCNT_W-1:0]  win_reg;
    logic [rlm_pkg::WCNT_W-1:0]  ones_reg;
    logic [rlm_pkg::WCNT_W-1:0]  run_reg;
    logic                        viol_reg;
    logic                        event_reg;
    logic [rlm_pkg::WCNT_W-1:0]  win_bits;
    logic [rlm_pkg::WCNT_W-1:0]  win_ones;
    logic [rlm_pkg::WCNT_W-1:0]  max_run;
    logic [rlm_pkg::WCNT_W-1:0]  win_next;
    logic [rlm_pkg::WCNT_W-1:0]  ones_next;
    logic [rlm_pkg::WCNT_W-1:0]  run_next;
    logic                        viol_next;
    logic                        declare;
    logic                        recovered;

    assign win_bits  = bits.t1_mode ? rlm_pkg::T1_WIN_BITS
                                    : rlm_pkg::E1_WIN_BITS;
    assign win_ones  = bits.t1_mode ? rlm_pkg::T1_WIN_ONES
                                    : rlm_pkg::E1_WIN_ONES;
    assign max_run   = bits.t1_mode ? rlm_pkg::T1_MAX_ZERO_RUN
                                    : rlm_pkg::E1_MAX_ZERO_RUN;
    assign win_next  = win_reg + 8'h01;
    assign ones_next = bits.bit_one ? ones_reg + 8'h01 : ones_reg;
    assign run_next  = bits.bit_one ? 8'h00 : run_reg + 8'h01;
    assign viol_next = viol_reg || (run_next > max_run);
    // zero run reaches its limit on this bit
    assign declare   = bits.bit_strobe && bits.low_level && !bits.bit_one
                       && (zrun_reg + 13'h0001
                           == zero_limit(bits.t1_mode, bits.ext_loss));
    // window complete with enough ones and no long run
    assign recovered = bits.bit_strobe && !bits.low_level
                       && (win_next == win_bits)
                       && (ones_next >= win_ones) && !viol_next;

    // ********************************************************
    // consecutive zero counter
    // ********************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            zrun_reg <= '0;
        else if (!bits.low_level)
            zrun_reg <= '0;
        else if (bits.bit_strobe && bits.bit_one)
            zrun_reg <= '0;
        else if (bits.bit_strobe && !declare)
            zrun_reg <= zrun_reg + 13'h0001;
    end

    // ********************************************************
    // ones-density window, only while loss stands and level is back
    // ********************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_reg == RLM_SIGNAL || bits.low_level)
        begin
            win_reg  <= '0;
            ones_reg <= '0;
            run_reg  <= '0;
            viol_reg <= 1'b0;
        end
        else if (bits.bit_strobe)
        begin
            if (win_next == win_bits)
            begin
                win_reg  <= '0;
                ones_reg <= '0;
                viol_reg <= 1'b0;
            end
            else
            begin
                win_reg  <= win_next;
                ones_reg <= ones_next;
                viol_reg <= viol_next;
            end
            // a zero run may span windows, so it is not cleared here
            run_reg <= run_next;
        end
    end

    // ********************************************************
    // loss state
    // ********************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= RLM_SIGNAL;
        else
            unique case (state_reg)
                RLM_SIGNAL:
                    if (declare)
                        state_reg <= RLM_LOSS;
                RLM_LOSS:
                    if (recovered)
                        state_reg <= RLM_SIGNAL;
            endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            event_reg <= 1'b0;
        else
            event_reg <= (state_reg == RLM_SIGNAL) && declare;
    end

    assign bits.loss       = (state_reg == RLM_LOSS);
    assign bits.loss_event = event_reg;
endmodule

// *** logic/rlm_rx_path.sv ***
/*
 * receive data path: optional fixed-depth jitter attenuator delay and
 * optional single-rail decoder with violation flag.
 * assumes one bit_strobe per received bit on aclk.
 */
module rlm_rx_path
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic bit_strobe,
    input  wire logic pos_in,
    input  wire logic neg_in,
    input  wire logic ja_enable,
    input  wire logic dec_enable,
    output logic      pos_out,
    output logic      neg_out
);
    logic [1:0] delay_reg [rlm_pkg::JA_DELAY_BITS];
    logic [1:0] stage;
    logic       last_pol_reg;
    logic       mark;

    // ********************************************************
    // jitter attenuator stand-in: bit-aligned delay line
    // ********************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < rlm_pkg::JA_DELAY_BITS; i++)
                delay_reg[i] <= 2'h0;
        end
        else if (bit_strobe)
        begin
            delay_reg[0] <= {pos_in, neg_in};
            for (int i = 1; i < rlm_pkg::JA_DELAY_BITS; i++)
                delay_reg[i] <= delay_reg[i-1];
        end
    end

    assign stage = ja_enable ? delay_reg[rlm_pkg::JA_DELAY_BITS-1]
                             : {pos_in, neg_in};
    assign mark  = stage[1] || stage[0];

    // ********************************************************
    // decoder: a mark of the same polarity as the last is a violation
    // ********************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            last_pol_reg <= 1'b0;
            pos_out      <= 1'b0;
            neg_out      <= 1'b0;
        end
        else if (bit_strobe)
        begin
            if (mark)
                last_pol_reg <= stage[1];
            if (dec_enable)
            begin
                pos_out <= mark;
                neg_out <= mark && (stage[1] == last_pol_reg);
            end
            else
            begin
                pos_out <= stage[1];
                neg_out <= stage[0];
            end
        end
    end
endmodule

// *** logic/rlm_monitor_top.sv ***
/*
 * receive loss-of-signal monitor with AXI4-Lite registers, active-low
 * alarm interrupt and receive data outputs.
 * assumes recovered clock, sliced bits and level indication arrive as
 * pins asynchronous to aclk, and the recovered clock is well below
 * aclk/4 so that each of its rising edges is seen once.
 */
// Function
// - E1: 32 zeros under low level declare loss
// - extended option (E1 only, T1 ignores it): 4096 zeros under low level declare loss
// - T1: 175 zeros under low level declare loss
// - E1 clear: 4 ones per 32, run<=16
// - T1 clear: 16 ones per 128, run<=100
// - loss updates indication and alarm status
// - enabled alarm drives interrupt output low
// - reading alarm status clears it, interrupt high
// - host mode: receiver-on bit switches receiver
// - pin mode: receiver always enabled
// - data through attenuator and decoder to outputs
module rlm_monitor_top
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_clk_pin,
    input  wire logic        rx_pos_pin,
    input  wire logic        rx_neg_pin,
    input  wire logic        analog_low_level_pin,
    input  wire logic        hw_mode_pin,
    output logic             rx_positive_data_out,
    output logic             rx_negative_or_violation_out,
    output logic             receive_signal_loss,
    output logic             irq_n
);
    localparam int SYNC_N = 5;

    rlm_bit_if bits ();

    logic [SYNC_N-1:0]         sync1_reg;
    logic [SYNC_N-1:0]         sync2_reg;
    logic                      clk_prev_reg;
    logic                      rx_clk_s;
    logic                      rx_pos_s;
    logic                      rx_neg_s;
    logic                      low_level_s;
    logic                      hw_mode_s;
    logic                      rx_enable;
    logic                      bit_strobe;
    logic [rlm_pkg::CTRL_W-1:0] ctrl_reg;
    logic                      alarm_reg;
    logic                      alarm_ena_reg;
    logic                      aw_got_reg;
    logic                      w_got_reg;
    logic [3:0]                awaddr_reg;
    logic [31:0]               wdata_reg;
    logic [3:0]                wstrb_reg;
    logic                      bvalid_reg;
    logic [1:0]                bresp_reg;
    logic                      rvalid_reg;
    logic [31:0]               rdata_reg;
    logic [1:0]                rresp_reg;
    logic                      aw_hs;
    logic                      w_hs;
    logic                      ar_hs;
    logic                      wr_fire;
    logic [3:0]                wr_addr;
    logic [31:0]               wr_data;
    logic [3:0]                wr_strb;
    logic                      alarm_read;
    logic                      alarm_w1c;

    function automatic logic reg_mapped
    (
        input logic [3:0] addr
    );
        return (addr == rlm_pkg::CTRL_OFFS) || (addr == rlm_pkg::STAT_OFFS)
            || (addr == rlm_pkg::ALARM_OFFS) || (addr == rlm_pkg::ENA_OFFS);
    endfunction

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            // the level indication crosses here too
            sync1_reg <= {hw_mode_pin, analog_low_level_pin,
                          rx_neg_pin, rx_pos_pin, rx_clk_pin};
            sync2_reg <= sync1_reg;
        end
    end

    assign rx_clk_s    = sync2_reg[0];
    assign rx_pos_s    = sync2_reg[1];
    assign rx_neg_s    = sync2_reg[2];
    assign low_level_s = sync2_reg[3];
    assign hw_mode_s   = sync2_reg[4];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clk_prev_reg <= 1'b0;
        else
            clk_prev_reg <= rx_clk_s;
    end

    // hardware mode keeps the receiver on regardless of the control bit
    assign rx_enable  = hw_mode_s
                        || ctrl_reg[rlm_pkg::CTRL_RECEIVER_POWER_ON_BIT];
    assign bit_strobe = rx_enable && rx_clk_s && !clk_prev_reg;

    // ********************************************************
    // detector and data path
    // ********************************************************
    assign bits.bit_strobe = bit_strobe;
    assign bits.bit_one    = rx_pos_s || rx_neg_s;
    assign bits.low_level  = low_level_s;
    assign bits.t1_mode    = ctrl_reg[rlm_pkg::CTRL_T1_BIT];
    assign bits.ext_loss   = ctrl_reg[rlm_pkg::CTRL_EXT_BIT];

    rlm_los_detect u_detect
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .bits    (bits)
    );

    rlm_rx_path u_path
    (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .bit_strobe (bit_strobe),
        .pos_in     (rx_pos_s),
        .neg_in     (rx_neg_s),
        .ja_enable  (ctrl_reg[rlm_pkg::CTRL_JA_BIT]),
        .dec_enable (ctrl_reg[rlm_pkg::CTRL_DEC_BIT]),
        .pos_out    (rx_positive_data_out),
        .neg_out    (rx_negative_or_violation_out)
    );

    assign receive_signal_loss = bits.loss;

    // ********************************************************
    // AXI4-Lite write channel
    // ********************************************************
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign aw_hs         = s_axi_awvalid && s_axi_awready;
    assign w_hs          = s_axi_wvalid && s_axi_wready;
    assign wr_fire       = (aw_got_reg || aw_hs) && (w_got_reg || w_hs);
    assign wr_addr       = aw_got_reg ? awaddr_reg : s_axi_awaddr;
    assign wr_data       = w_got_reg ? wdata_reg : s_axi_wdata;
    assign wr_strb       = w_got_reg ? wstrb_reg : s_axi_wstrb;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
        end
        else if (wr_fire)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= rlm_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= reg_mapped(wr_addr) ? rlm_pkg::RESP_OKAY
                                              : rlm_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg      <= rlm_pkg::CTRL_RESET;
            alarm_ena_reg <= 1'b0;
        end
        else if (wr_fire && wr_strb[0])
        begin
            if (wr_addr == rlm_pkg::CTRL_OFFS)
                ctrl_reg <= wr_data[rlm_pkg::CTRL_W-1:0];
            if (wr_addr == rlm_pkg::ENA_OFFS)
                alarm_ena_reg <= wr_data[rlm_pkg::ALARM_LOSS_BIT];
        end
    end

    // ********************************************************
    // AXI4-Lite read channel
    // ********************************************************
    assign s_axi_arready = !rvalid_reg;
    assign ar_hs         = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= rlm_pkg::RESP_OKAY;
        end
        else if (ar_hs)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= reg_mapped(s_axi_araddr) ? rlm_pkg::RESP_OKAY
                                                   : rlm_pkg::RESP_SLVERR;
            rdata_reg  <= 32'h00000000;
            unique case (s_axi_araddr)
                rlm_pkg::CTRL_OFFS:
                    rdata_reg[rlm_pkg::CTRL_W-1:0] <= ctrl_reg;
                rlm_pkg::STAT_OFFS:
                begin
                    rdata_reg[rlm_pkg::STAT_LOSS_BIT] <= bits.loss;
                    rdata_reg[rlm_pkg::STAT_RXEN_BIT] <= rx_enable;
                    rdata_reg[rlm_pkg::STAT_HW_BIT]   <= hw_mode_s;
                end
                rlm_pkg::ALARM_OFFS:
                    rdata_reg[rlm_pkg::ALARM_LOSS_BIT] <= alarm_reg;
                rlm_pkg::ENA_OFFS:
                    rdata_reg[rlm_pkg::ALARM_LOSS_BIT] <= alarm_ena_reg;
                default:
                    rdata_reg <= 32'h00000000;
            endcase
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // ********************************************************
    // alarm status and interrupt
    // ********************************************************
    assign alarm_read = ar_hs && (s_axi_araddr == rlm_pkg::ALARM_OFFS);
    assign alarm_w1c  = wr_fire && wr_strb[0]
                        && (wr_addr == rlm_pkg::ALARM_OFFS)
                        && wr_data[rlm_pkg::ALARM_LOSS_BIT];

    // a new loss in the clearing cycle survives: set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            alarm_reg <= 1'b0;
        else if (bits.loss_event)
            alarm_reg <= 1'b1;
        else if (alarm_read || alarm_w1c)
            alarm_reg <= 1'b0;
    end

    assign irq_n = !(alarm_reg && alarm_ena_reg);

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;
endmodule

// *** bench/rlm_assertions.sv ***
/* checker on the monitor's top ports: bus handshakes and interrupt.
   assumes it is bound into rlm_monitor_top. */
module rlm_assertions
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       irq_n,
    input wire logic       receive_signal_loss
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // loss seen twice means its alarm set has landed before the read
    sequence s_alarm_read;
        s_rd_taken ##0 s_axi_araddr == rlm_pkg::ALARM_OFFS
            ##0 receive_signal_loss && $past(receive_signal_loss);
    endsequence
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_clears: assert property (s_alarm_read |=> irq_n)
        else $error("alarm read left interrupt low");
    a_irq_cause: assert property ($fell(irq_n) |->
        receive_signal_loss || $rose(s_axi_bvalid)) else $error("bad irq");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("response repeated");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read data repeated");
endmodule

// *** bench/rlm_front_end.sv ***
/* front end model: sliced rails and recovered bit clock.
   assumes send_bit is called just after a rising aclk edge. */
module rlm_front_end
(
    input  wire logic aclk,
    output logic      rx_clk_pin,
    output logic      rx_pos_pin,
    output logic      rx_neg_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pol = 1'b0;
    initial {rx_clk_pin, rx_pos_pin, rx_neg_pin} = 3'h0;
    // marks alternate rails like a bipolar line; the bit clock stands
    // low between bits, each phase long enough for a 2-stage sync
    task automatic send_bit(input logic b);
        @(posedge aclk);
        rx_pos_pin <= b & ~pol;
        rx_neg_pin <= b & pol;
        pol = pol ^ b;
        @(posedge aclk);
        rx_clk_pin <= 1'b1;
        repeat (3) @(posedge aclk);
        rx_clk_pin <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
endmodule

// *** bench/rlm_monitor_top_test.sv ***
/* self-checking test of the loss monitor through pins and registers.
   assumes the checker and the front end model are compiled first. */
bind rlm_monitor_top rlm_assertions chk (.*);
module rlm_monitor_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0, hw_mode_pin = 1'b0, b;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, analog_low_level_pin = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, irq_n, receive_signal_loss;
    logic        rx_positive_data_out, rx_negative_or_violation_out;
    logic        rx_clk_pin, rx_pos_pin, rx_neg_pin;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, exp_q[$];
    int          error_cnt = 0, total_checks = 0;

    rlm_monitor_top dut (.*);
    rlm_front_end fe (.*);
    initial forever #10 aclk = ~aclk;

    task automatic summarize;
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic fail(input string s);
        error_cnt++;
        $display("Error at %0t: %s", $time, s);
    endtask
    task automatic check_word(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) fail("bus value mismatch");
    endtask
    task automatic check_bit(input logic g, e);
        total_checks++;
        if (g !== e) fail("pin mismatch");
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, r);
        int n = 0;
        exp_q.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= {3'($urandom), 1'b1};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end
        while (n < 40 && !s_axi_bvalid);
        if (!s_axi_bvalid) summarize_after_timeout();
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        int n = 0;
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end
        while (n < 40 && !s_axi_rvalid);
        if (!s_axi_rvalid) summarize_after_timeout();
    endtask
    task automatic summarize_after_timeout;
        fail("timeout");
        summarize();
    endtask

    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            check_word(s_axi_rdata | {s_axi_rresp, 30'h0},
                       exp_q.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check_word({30'h0, s_axi_bresp}, exp_q.pop_front());
    end

    task automatic loss_cycle(input int n, input logic [31:0] c, input int w);
        wr(4'h0, c, 32'h0);
        analog_low_level_pin <= 1'b1;
        repeat (n - 1) fe.send_bit(1'b0);
        check_bit(receive_signal_loss, 1'b0);
        fe.send_bit(1'b1);
        repeat (n - 1) fe.send_bit(1'b0);
        check_bit(receive_signal_loss, 1'b0);
        fe.send_bit(1'b0);
        check_bit(receive_signal_loss, 1'b1);
        check_bit(irq_n, 1'b0);
        rd(4'h4, 32'h3);
        rd(4'h8, 32'h1);
        check_bit(irq_n, 1'b1);
        analog_low_level_pin <= 1'b0;
        for (int i = 1; i <= w; i++)
        begin
            check_bit(receive_signal_loss, 1'b1);
            fe.send_bit(i % 8 == 1);
        end
        check_bit(receive_signal_loss, 1'b0);
        $display("loss test %0d done", n);
    endtask

    initial
    begin
        void'($urandom(85));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(4'h0, 32'h0);
        rd(4'hC, 32'h0);
        rd(4'h6, 32'h80000000);
        wr(4'h2, 32'h1, 32'h2);
        wr(4'hC, 32'h1, 32'h0);
        $display("register test done");
        loss_cycle(32, 32'h4, 32);
        loss_cycle(175, 32'h5, 128);
        loss_cycle(4096, 32'h6, 32);
        hw_mode_pin <= 1'b1;
        wr(4'h0, 32'h0, 32'h0);
        rd(4'h4, 32'h6);
        hw_mode_pin <= 1'b0;
        wr(4'h0, 32'h4, 32'h0);
        repeat (8)
        begin
            b = 1'($urandom);
            fe.send_bit(b);
            check_bit(rx_positive_data_out, rx_pos_pin);
            check_bit(rx_negative_or_violation_out, rx_neg_pin);
        end
        wr(4'h0, 32'hC, 32'h0);
        fe.send_bit(1'b1);
        wr(4'h0, 32'h10, 32'h0);
        rd(4'h4, 32'h0);
        fe.send_bit(1'b0);
        b = rx_positive_data_out & ~rx_negative_or_violation_out;
        check_bit(b, 1'b1);
        $display("data path test done");
        summarize();
    end
endmodule
